// *** src/lnk66_pkg.sv ***
// How it works
// - Eight octets form one 64-bit payload block
// - Scramble payload, then prepend two-bit header
// - Thirty-two blocks make one multiblock
// - Only one multiblock per extended multiblock
// - Extended multiblock holds whole frames only
// - SYSREF edge resets multiblock clock phase
// - Multiblock clock is line rate over 66x32xE
// - Header bits always complementary, 01 or 10
// - Header 10 sends 1, 01 sends 0
// - Only CRC-12 stream mode built here
// - Stream ends 00001, unique in CRC mode
// - Stream bit 22 flags extended multiblock end
// - Parity of one multiblock sent in next
// - Parity bits placed MSB first, skipping fours
// - Seven command bits always driven zero
// - Fixed ones and zeros in CRC stream
// - Parity polynomial is 0x987
// - Parity covers 2048 payload bits, starts zero
package lnk66_pkg;

    // ==========================================
    // Block layout
    localparam int unsigned OCTETS_PER_BLOCK = 8;
    localparam int unsigned PAYLOAD_BITS = 64;
    localparam int unsigned HDR_BITS = 2;
    localparam int unsigned BLOCK_BITS = 66;
    localparam logic [1:0] HDR_ONE = 2'h2;
    localparam logic [1:0] HDR_ZERO = 2'h1;

    // ==========================================
    // Multiblock and clocking
    localparam int unsigned MB_BLOCKS = 32;
    localparam int unsigned EXT_MB = 1;
    localparam int unsigned IDX_W = 5;
    localparam logic [4:0] IDX_FIRST = 5'h00;
    localparam logic [4:0] IDX_LAST = 5'h1f;
    localparam logic [4:0] XCLK_HIGH_BLOCKS = 5'h10;
    localparam int unsigned CLK_PERIOD_NS = 8;
    // One block per clock: line rate is BLOCK_BITS per period
    localparam int unsigned XCLK_PERIOD_CYCLES = MB_BLOCKS * EXT_MB;
    localparam int unsigned XCLK_PERIOD_NS = XCLK_PERIOD_CYCLES * CLK_PERIOD_NS;

    // ==========================================
    // Header stream layout
    localparam int unsigned SHS_XEND_BIT = 22;
    localparam int unsigned SHS_MEND_FIRST = 27;
    localparam logic [31:0] SHS_ONES_MASK = 32'h80a88888;
    localparam logic [31:0] SHS_CMD_MASK = 32'h07170000;
    localparam logic [31:0] SHS_ZERO_MASK = 32'h78000000;
    localparam int unsigned SHS_PAR_GROUPS = 4;
    localparam int unsigned SHS_GROUP_W = 4;
    localparam int unsigned SHS_PAR_PER_GROUP = 3;

    // ==========================================
    // Parity and scrambler
    localparam int unsigned CRC_W = 12;
    localparam logic [11:0] CRC_POLY = 12'h987;
    localparam logic [11:0] CRC_INIT = 12'h000;
    localparam int unsigned SCR_W = 58;
    localparam int unsigned SCR_TAP_A = 39;
    localparam int unsigned SCR_TAP_B = 58;
    localparam logic [57:0] SCR_INIT = 58'h0;

    typedef struct packed {
        logic [63:0] payload;
        logic [1:0] header;
    } lnk66_block_s;

    // Stream word; bit k rides in the header of block k
    function automatic logic [31:0] lnk66_stream(input logic [11:0] par, input logic xend);
        logic [31:0] w;
        w = SHS_ONES_MASK;
        for (int g = 0; g < SHS_PAR_GROUPS; g++) begin
            for (int j = 0; j < SHS_PAR_PER_GROUP; j++) begin
                w[g * SHS_GROUP_W + j] = par[CRC_W - 1 - g * SHS_PAR_PER_GROUP - j];
            end
        end
        w[SHS_XEND_BIT] = xend;
        return w;
    endfunction : lnk66_stream

endpackage : lnk66_pkg

// *** src/lnk66_scrambler.sv ***
`timescale 1ns/1ns
module lnk66_scrambler (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic advance,
    input wire logic [63:0] data_in,
    output logic [63:0] data_out
);

    // ==========================================
    // Self-synchronous scrambler, bit 0 sent first
    logic [57:0] state_q;
    logic [57:0] state_d;

    always_comb begin
        logic [57:0] s;
        logic b;
        s = state_q;
        b = 1'b0;
        data_out = '0;
        for (int i = 0; i < lnk66_pkg::PAYLOAD_BITS; i++) begin
            b = data_in[i] ^ s[lnk66_pkg::SCR_TAP_A - 1] ^ s[lnk66_pkg::SCR_TAP_B - 1];
            data_out[i] = b;
            s = {s[56:0], b};
        end
        state_d = s;
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            state_q <= lnk66_pkg::SCR_INIT;
        end else if (advance) begin
            state_q <= state_d;
        end
    end

    // Zero state with zero data must stay zero
    property p_scr_zero;
        @(posedge clock) disable iff (sys_rst)
        advance && (state_q == '0) && (data_in == '0) |-> data_out == '0;
    endproperty
    a_scr_zero: assert property (p_scr_zero) else $error("scrambler leaks state");

endmodule : lnk66_scrambler

// *** src/lnk66_crc12.sv ***
`timescale 1ns/1ns
module lnk66_crc12 (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic update,
    input wire logic start,
    input wire logic [63:0] data_in,
    output logic [11:0] result
);

    // ==========================================
    // Serial-equivalent parity over one block
    logic [11:0] crc_q;

    always_comb begin
        logic [11:0] c;
        logic fb;
        c = start ? lnk66_pkg::CRC_INIT : crc_q;
        fb = 1'b0;
        for (int i = 0; i < lnk66_pkg::PAYLOAD_BITS; i++) begin
            fb = c[lnk66_pkg::CRC_W - 1] ^ data_in[i];
            c = {c[10:0], 1'b0} ^ (fb ? lnk66_pkg::CRC_POLY : lnk66_pkg::CRC_INIT);
        end
        result = c;
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            crc_q <= lnk66_pkg::CRC_INIT;
        end else if (update) begin
            crc_q <= result;
        end
    end

    // Linear code: zero input from a fresh start gives zero
    property p_crc_fresh;
        @(posedge clock) disable iff (sys_rst)
        update && start && (data_in == '0) |-> result == '0;
    endproperty
    a_crc_fresh: assert property (p_crc_fresh) else $error("parity not seeded at zero");

    property p_crc_single;
        @(posedge clock) disable iff (sys_rst)
        update && start && (data_in == 64'h8000000000000000) |-> result == lnk66_pkg::CRC_POLY;
    endproperty
    a_crc_single: assert property (p_crc_single) else $error("parity polynomial wrong");

endmodule : lnk66_crc12

// *** src/lnk66_framer.sv ***
`timescale 1ns/1ns
module lnk66_framer #(
    parameter int unsigned FRAME_OCTETS = 4,
    parameter int unsigned EXT_MB = lnk66_pkg::EXT_MB
) (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic sysref,
    input wire logic in_valid,
    input wire logic [63:0] in_data,
    output logic out_valid,
    output lnk66_pkg::lnk66_block_s out_block,
    output logic [4:0] out_index,
    output logic ext_multiblock_clock,
    output logic ext_multiblock_end
);

    // ==========================================
    // Elaboration checks
    if (EXT_MB != 1) begin : g_bad_ext
        $error("only one multiblock per extended multiblock");
    end
    if (((lnk66_pkg::MB_BLOCKS * lnk66_pkg::OCTETS_PER_BLOCK * EXT_MB) % FRAME_OCTETS) != 0)
    begin : g_bad_frame
        $error("extended multiblock must hold whole frames");
    end
    if (FRAME_OCTETS == 0) begin : g_zero_frame
        $error("frame size must be nonzero");
    end

    // ==========================================
    // State
    logic sysref_q;
    logic [4:0] idx_q;
    logic [4:0] idx_d;
    logic [11:0] par_q;
    logic out_valid_q;
    lnk66_pkg::lnk66_block_s out_block_q;
    logic [4:0] out_index_q;
    logic xclk_q;
    logic ext_end_q;

    // ==========================================
    // Decode
    wire sysref_rise = sysref & ~sysref_q;
    // Block taken with the SYSREF edge is block 0 of a fresh multiblock
    wire [4:0] idx_use = sysref_rise ? lnk66_pkg::IDX_FIRST : idx_q;
    wire mb_first = (idx_use == lnk66_pkg::IDX_FIRST);
    wire mb_last = (idx_use == lnk66_pkg::IDX_LAST);
    // Octet 0 arrives in the top byte; payload bit 0 is sent first
    wire [63:0] tx_order = {<<{in_data}};
    wire [63:0] scrambled;
    wire [11:0] crc_res;
    // Only one multiblock per extended multiblock, so every one is the last
    wire xend = 1'b1;
    wire [31:0] stream_word = lnk66_pkg::lnk66_stream(par_q, xend);
    wire stream_bit = stream_word[idx_use];
    wire [1:0] header = stream_bit ? lnk66_pkg::HDR_ONE : lnk66_pkg::HDR_ZERO;
    wire [4:0] idx_inc = mb_last ? lnk66_pkg::IDX_FIRST : 5'(idx_use + 5'h01);

    assign idx_d = in_valid ? idx_inc : idx_use;

    // ==========================================
    // Scrambler and parity
    lnk66_scrambler u_scr (
        .clock(clock),
        .sys_rst(sys_rst),
        .advance(in_valid),
        .data_in(tx_order),
        .data_out(scrambled)
    );

    // Scrambled payload only; headers never enter the parity
    lnk66_crc12 u_crc (
        .clock(clock),
        .sys_rst(sys_rst),
        .update(in_valid),
        .start(mb_first),
        .data_in(scrambled),
        .result(crc_res)
    );

    // ==========================================
    // Registers
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            sysref_q <= 1'b0;
            idx_q <= lnk66_pkg::IDX_FIRST;
        end else begin
            sysref_q <= sysref;
            idx_q <= idx_d;
        end
    end

    // Partial multiblock cut by SYSREF keeps the older parity
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            par_q <= lnk66_pkg::CRC_INIT;
        end else if (in_valid && mb_last) begin
            par_q <= crc_res;
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            out_valid_q <= 1'b0;
            out_block_q <= '0;
            out_index_q <= lnk66_pkg::IDX_FIRST;
            ext_end_q <= 1'b0;
        end else begin
            out_valid_q <= in_valid;
            if (in_valid) begin
                out_block_q <= '{payload: scrambled, header: header};
                out_index_q <= idx_use;
                ext_end_q <= mb_last;
            end else begin
                ext_end_q <= 1'b0;
            end
        end
    end

    // High for the first half of each multiblock period
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            xclk_q <= 1'b1;
        end else begin
            xclk_q <= (idx_d < lnk66_pkg::XCLK_HIGH_BLOCKS);
        end
    end

    assign out_valid = out_valid_q;
    assign out_block = out_block_q;
    assign out_index = out_index_q;
    assign ext_multiblock_clock = xclk_q;
    assign ext_multiblock_end = ext_end_q;

    // ==========================================
    // Assertions
    property p_hdr_compl;
        @(posedge clock) disable iff (sys_rst)
        out_valid_q |-> out_block_q.header[0] != out_block_q.header[1];
    endproperty
    a_hdr_compl: assert property (p_hdr_compl) else $error("header not complementary");

    property p_hdr_stream;
        @(posedge clock) disable iff (sys_rst)
        out_valid_q && (out_index_q != lnk66_pkg::IDX_LAST)
        |-> out_block_q.header[1] == stream_word[out_index_q];
    endproperty
    a_hdr_stream: assert property (p_hdr_stream) else $error("header disagrees with stream");

    property p_mend;
        @(posedge clock) disable iff (sys_rst)
        out_valid_q && (out_index_q >= 5'(lnk66_pkg::SHS_MEND_FIRST))
        |-> out_block_q.header[1] == (out_index_q == lnk66_pkg::IDX_LAST);
    endproperty
    a_mend: assert property (p_mend) else $error("end of multiblock pattern wrong");

    property p_xend;
        @(posedge clock) disable iff (sys_rst)
        out_valid_q && (out_index_q == 5'(lnk66_pkg::SHS_XEND_BIT))
        |-> out_block_q.header == lnk66_pkg::HDR_ONE;
    endproperty
    a_xend: assert property (p_xend) else $error("extended end flag not set");

    property p_cmd_zero;
        @(posedge clock) disable iff (sys_rst)
        out_valid_q && lnk66_pkg::SHS_CMD_MASK[out_index_q]
        |-> out_block_q.header == lnk66_pkg::HDR_ZERO;
    endproperty
    a_cmd_zero: assert property (p_cmd_zero) else $error("command bit not zero");

    property p_fixed;
        @(posedge clock) disable iff (sys_rst)
        out_valid_q && (lnk66_pkg::SHS_ONES_MASK[out_index_q] || lnk66_pkg::SHS_ZERO_MASK[out_index_q])
        |-> out_block_q.header[1] == lnk66_pkg::SHS_ONES_MASK[out_index_q];
    endproperty
    a_fixed: assert property (p_fixed) else $error("fixed stream bit wrong");

    property p_par_msb;
        @(posedge clock) disable iff (sys_rst)
        out_valid_q && (out_index_q == lnk66_pkg::IDX_FIRST)
        |-> out_block_q.header[1] == par_q[lnk66_pkg::CRC_W - 1];
    endproperty
    a_par_msb: assert property (p_par_msb) else $error("parity msb misplaced");

    property p_par_latch;
        @(posedge clock) disable iff (sys_rst)
        in_valid && mb_last |=> par_q == $past(crc_res) && ext_end_q;
    endproperty
    a_par_latch: assert property (p_par_latch) else $error("parity not carried over");

    property p_wrap;
        @(posedge clock) disable iff (sys_rst)
        in_valid && mb_last ##1 in_valid && !sysref_rise |=> out_index_q == lnk66_pkg::IDX_FIRST;
    endproperty
    a_wrap: assert property (p_wrap) else $error("multiblock does not wrap");

    property p_sysref;
        @(posedge clock) disable iff (sys_rst)
        sysref_rise && in_valid |=> out_valid_q && out_index_q == lnk66_pkg::IDX_FIRST;
    endproperty
    a_sysref: assert property (p_sysref) else $error("sysref did not realign");

    property p_xclk;
        @(posedge clock) disable iff (sys_rst)
        ext_end_q && !$past(sysref_rise) |-> xclk_q;
    endproperty
    a_xclk: assert property (p_xclk) else $error("multiblock clock phase wrong");

    property p_cv_realign;
        @(posedge clock) disable iff (sys_rst)
        sysref_rise && in_valid && !mb_first;
    endproperty
    c_realign: cover property (p_cv_realign);

    property p_cv_mb_end;
        @(posedge clock) disable iff (sys_rst)
        ext_end_q ##1 out_valid_q;
    endproperty
    c_mb_end: cover property (p_cv_mb_end);

    property p_cv_par_one;
        @(posedge clock) disable iff (sys_rst)
        out_valid_q && out_index_q == lnk66_pkg::IDX_FIRST && out_block_q.header[1];
    endproperty
    c_par_one: cover property (p_cv_par_one);

endmodule : lnk66_framer

// *** tb/lnk66_rx_model.sv ***
`timescale 1ns/1ns
module lnk66_rx_model (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic out_valid,
    input wire lnk66_pkg::lnk66_block_s out_block,
    input wire logic [4:0] out_index,
    output logic [15:0] bad_count,
    output logic [15:0] checked_count
);
    // ==========================================
    // Receiver-side parity and header stream check
    logic [11:0] acc_q;
    logic [11:0] prev_q;
    logic [31:0] shs_q;
    logic [11:0] seed;
    logic [11:0] next_crc;
    logic hdr_ok;

    function automatic logic [11:0] crc_step(input logic [11:0] c, input logic [63:0] p);
        logic fb;
        for (int i = 0; i < 64; i++) begin
            fb = c[11] ^ p[i];
            c = {c[10:0], 1'b0};
            if (fb) c = c ^ lnk66_pkg::CRC_POLY;
        end
        return c;
    endfunction : crc_step

    function automatic logic [31:0] exp_shs(input logic [11:0] par);
        logic [31:0] w;
        w = 32'h80e88888;
        for (int g = 0; g < 4; g++) begin
            for (int j = 0; j < 3; j++) begin
                w[g * 4 + j] = par[11 - g * 3 - j];
            end
        end
        return w;
    endfunction : exp_shs

    // Interrupted multiblock simply restarts at index 0; old parity kept
    assign seed = (out_index == 5'h00) ? 12'h000 : acc_q;
    assign next_crc = crc_step(seed, out_block.payload);
    assign hdr_ok = ^out_block.header;

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            acc_q <= 12'h000;
            prev_q <= 12'h000;
            shs_q <= 32'h00000000;
            bad_count <= 16'h0000;
            checked_count <= 16'h0000;
        end else if (out_valid) begin
            shs_q[out_index] <= out_block.header[1];
            acc_q <= next_crc;
            if (!hdr_ok) bad_count <= bad_count + 16'h0001;
            if (out_index == 5'h1f) begin
                prev_q <= next_crc;
                checked_count <= checked_count + 16'h0001;
                if ({out_block.header[1], shs_q[30:0]} !== exp_shs(prev_q)) begin
                    bad_count <= bad_count + 16'h0001;
                end
            end
        end
    end
endmodule : lnk66_rx_model

// *** tb/link_64b66b_block_crc_framer_test.sv ***
`timescale 1ns/1ns
module link_64b66b_block_crc_framer_test;
    logic clock = 1'b0;
    logic sys_rst = 1'b1;
    logic sysref = 1'b0;
    logic in_valid = 1'b0;
    logic [63:0] in_data = 64'h0;
    logic out_valid;
    lnk66_pkg::lnk66_block_s out_block;
    logic [4:0] out_index;
    logic xclk;
    logic mb_end;
    logic [15:0] rx_bad;
    logic [15:0] rx_checked;
    int err_count = 0;
    int n_checks = 0;
    int cyc = 0;
    logic [57:0] scr_s = 58'h0;
    logic [4:0] exp_idx = 5'h00;
    logic last_ref = 1'b0;

    lnk66_framer #(.FRAME_OCTETS(4), .EXT_MB(1)) u_dut (
        .clock(clock), .sys_rst(sys_rst), .sysref(sysref), .in_valid(in_valid),
        .in_data(in_data), .out_valid(out_valid), .out_block(out_block),
        .out_index(out_index), .ext_multiblock_clock(xclk), .ext_multiblock_end(mb_end));
    lnk66_rx_model u_rx (
        .clock(clock), .sys_rst(sys_rst), .out_valid(out_valid), .out_block(out_block),
        .out_index(out_index), .bad_count(rx_bad), .checked_count(rx_checked));

    // ==========================================
    // Clock, timeout, common tasks
    initial begin
        forever #4 clock = ~clock;
    end

    always @(posedge clock) begin
        cyc++;
        if (cyc == 5000) begin
            err_count++;
            complete_run();
        end
    end

    task automatic check(input string name, input logic [65:0] exp, input logic [65:0] got);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask : check

    function automatic logic [63:0] pat(input int n);
        return {32'h9e3779b9 * n, 32'h7f4a7c15 ^ (n << 3)};
    endfunction : pat

    // Holds in_valid high so back-to-back calls keep the stream dense
    task automatic send(input logic [63:0] d, input logic sref);
        logic [63:0] e;
        logic b;
        for (int i = 0; i < 64; i++) begin
            b = d[63 - i] ^ scr_s[38] ^ scr_s[57];
            e[i] = b;
            scr_s = {scr_s[56:0], b};
        end
        if (sref && !last_ref) exp_idx = 5'h00;
        last_ref = sref;
        in_valid = 1'b1;
        in_data = d;
        sysref = sref;
        @(posedge clock);
        #1;
        check("out_valid", 66'h1, out_valid);
        check("payload", e, out_block.payload);
        check("hdr_xor", 66'h1, ^out_block.header);
        check("index", exp_idx, out_index);
        check("mb_end", exp_idx == 5'h1f, mb_end);
        check("xclk", (5'(exp_idx + 5'h01)) < 5'h10, xclk);
        exp_idx = exp_idx + 5'h01;
    endtask : send

    task automatic idle(input int n);
        logic [4:0] held;
        in_valid = 1'b0;
        held = out_index;
        repeat (n) begin
            @(posedge clock);
            #1;
            check("idle_valid", 66'h0, out_valid);
            check("idle_end", 66'h0, mb_end);
            check("idle_index", held, out_index);
        end
    endtask : idle

    task automatic rx_ok(input logic [15:0] n);
        check("rx_checked", n, rx_checked);
        check("rx_bad", 66'h0, rx_bad);
    endtask : rx_ok

    // ==========================================
    // Scenarios
    task automatic t_reset();
        #1;
        check("rst_valid", 66'h0, out_valid);
        check("rst_index", 66'h0, out_index);
        check("rst_xclk", 66'h1, xclk);
        check("rst_end", 66'h0, mb_end);
    endtask : t_reset

    task automatic t_dense();
        for (int n = 0; n < 96; n++) send(pat(n), 1'b0);
        idle(1);
        rx_ok(16'h0003);
    endtask : t_dense

    task automatic t_gaps();
        for (int n = 0; n < 32; n++) begin
            send(pat(n + 200), 1'b0);
            if (n % 3 == 0) idle(2);
        end
        idle(1);
        rx_ok(16'h0004);
    endtask : t_gaps

    task automatic t_sysref();
        for (int n = 0; n < 7; n++) send(pat(n + 300), 1'b0);
        send(64'hffffffffffffffff, 1'b1);
        for (int n = 0; n < 40; n++) send(pat(n + 400), 1'b1);
        for (int n = 0; n < 24; n++) send(64'h0, 1'b0);
        idle(1);
        rx_ok(16'h0006);
    endtask : t_sysref

    task automatic complete_run();
        if (err_count == 0 && n_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : complete_run

    initial begin
        repeat (4) @(posedge clock);
        #1;
        sys_rst = 1'b0;
        t_reset();
        t_dense();
        t_gaps();
        t_sysref();
        complete_run();
    end
endmodule : link_64b66b_block_crc_framer_test
